/* File: core/sfu_core.sv */
// Serial format unit: registers on the bus, transmit holding stage, shifter and receiver.
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module sfu_core
	import sfu_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        ser_rxd,
	output logic             ser_txd,
	output logic             ser_sck,
	output logic             irq
);

	// All state of the unit, except the baud divider's, in one word.
	typedef struct packed {
		logic [7:0]  serial_format_register; // Character format.
		logic [7:0]  tx_holding_register;    // Byte waiting to be sent.
		logic [2:0]  ctl;                    // Enables and multiprocessor bit.
		logic [7:0]  div;                    // Bit-rate divisor.
		logic [5:0]  evt;                    // Sticky events.
		logic [5:0]  mask;                   // Event mask.
		logic [7:0]  rxd;                    // Last received byte.
		logic        tx_empty_flag;          // Holding register has no new byte.
		logic        mproc_rx;               // Multiprocessor bit last received.
		sfu_tx_st_t  tx_st;                  // Transmit sequencer.
		logic [3:0]  tx_tick;                // Tick within current bit.
		logic [3:0]  tx_left;                // Bits left in frame.
		logic [11:0] tx_frm;                 // Frame shifter, bit 0 on the line.
		logic        txd;                    // Line output.
		logic        sck;                    // Clock output, synchronous mode.
		sfu_rx_st_t  rx_st;                  // Receive sequencer.
		logic [3:0]  rx_tick;                // Tick within current bit.
		logic [3:0]  rx_idx;                 // Next frame bit to store.
		logic [11:0] rx_frm;                 // Received frame bits.
		logic        wait_n;                 // Low for the answering cycle.
		logic [31:0] rdata;                  // Read data to the bus.
		logic        irq;                    // Interrupt level.
		logic        rx_meta;                // First synchroniser stage.
		logic        rx_sync;                // Second synchroniser stage.
	} sfu_state_t;

	sfu_state_t s_q;
	sfu_state_t s_d;
	logic       tick;       // Baud tick, sixteen per bit.
	logic       fin;        // Last bit of a frame is ending.
	logic       sync_m;     // Synchronous mode selected.
	logic [5:0] ev_set;     // Events raised this cycle.
	logic [5:0] ev_clr;     // Events cleared by software.
	logic       del;        // A received character is ready.
	logic [7:0] del_data;   // Its data.
	logic       del_perr;   // Its parity error.
	logic       del_ferr;   // Its framing error.
	logic [3:0] pos;        // Stop bit position of the frame.

	sfu_baud u_baud (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.prescaler_sel ({s_q.serial_format_register[SFU_FMT_PRESCALER_SELECT_HI],
		                 s_q.serial_format_register[SFU_FMT_PRESCALER_SELECT_LO]}),
		.divisor       (s_q.div),
		.tick          (tick)
	);

	// Data bits per character: seven only when asynchronous and selected.
	function automatic logic [3:0] sfu_ndata(input logic [7:0] f);
		if (!f[SFU_FMT_SYNC_MODE] && f[SFU_FMT_CHAR_LENGTH_SELECT]) begin // [RQ6]
			return 4'h7;
		end
		return 4'h8;
	endfunction

	// An extra bit follows the data when parity or multiprocessor format applies.
	function automatic logic sfu_extra(input logic [7:0] f);
		return !f[SFU_FMT_SYNC_MODE] && (f[SFU_FMT_MULTIPROC_FORMAT] || f[SFU_FMT_PARITY_ENABLE]); // [RQ8]
	endfunction

	// Position of the first stop bit: start, data and extra bit precede it.
	function automatic logic [3:0] sfu_stop_pos(input logic [7:0] f);
		return 4'h1 + sfu_ndata(f) + {3'h0, sfu_extra(f)};
	endfunction

	// Parity over the character; even gives an even total of ones.
	function automatic logic sfu_parity(input logic [7:0] d, input logic [7:0] f);
		logic [7:0] m;
		m = d;
		if (sfu_ndata(f) == 4'h7) begin
			m[7] = 1'b0;
		end
		return (^m) ^ f[SFU_FMT_ODD]; // [RQ9] [RQ10]
	endfunction

	// Build a whole frame, bit 0 first on the line, idle ones beyond the end.
	function automatic logic [11:0] sfu_frame(input logic [7:0] d, input logic [7:0] f, input logic mb);
		logic [11:0] fr;
		logic [3:0]  n;
		fr = 12'hFFF;
		n  = sfu_ndata(f);
		if (f[SFU_FMT_SYNC_MODE]) begin
			// Clocked mode sends the bare byte: no start, parity or stop.
			fr[7:0] = d; // [RQ5] [RQ11]
		end else begin
			fr[0] = 1'b0;
			for (int i = 0; i < 8; i++) begin
				if (4'(i) < n) begin
					fr[i + 1] = d[i]; // [RQ7] [RQ16]
				end
			end
			if (f[SFU_FMT_MULTIPROC_FORMAT]) begin
				fr[4'h1 + n] = mb; // [RQ13]
			end else if (f[SFU_FMT_PARITY_ENABLE]) begin
				fr[4'h1 + n] = sfu_parity(d, f); // [RQ8]
			end
		end
		return fr;
	endfunction

	// Frame length in bits, stop bits included.
	function automatic logic [3:0] sfu_len(input logic [7:0] f);
		if (f[SFU_FMT_SYNC_MODE]) begin
			return 4'h8;
		end
		return sfu_stop_pos(f) + 4'h1 + {3'h0, f[SFU_FMT_TWO_STOP]}; // [RQ11]
	endfunction

	// Next-state logic for the whole unit.
	always_comb begin
		s_d      = s_q;
		ev_set   = '0;
		ev_clr   = '0;
		fin      = 1'b0;
		del      = 1'b0;
		del_data = 8'h00;
		del_perr = 1'b0;
		del_ferr = 1'b0;
		sync_m   = s_q.serial_format_register[SFU_FMT_SYNC_MODE]; // [RQ5]
		pos      = sfu_stop_pos(s_q.serial_format_register);

		// The raw line crosses into this clock through two flops.
		s_d.rx_meta = ser_rxd;
		s_d.rx_sync = s_q.rx_meta;

		// Advance the transmit shifter on each baud tick.
		if (s_q.tx_st == SFU_TX_SHIFT && tick) begin
			s_d.tx_tick = s_q.tx_tick + 4'h1;
			// In clocked mode the receiver samples at the clock's rising edge.
			if (sync_m && s_q.ctl[SFU_CTL_RX_ENABLE] && s_q.tx_tick == SFU_TICK_MID) begin
				s_d.rx_frm[s_q.rx_idx] = s_q.rx_sync;
				s_d.rx_idx = s_q.rx_idx + 4'h1;
				if (s_q.rx_idx == 4'h7) begin
					del      = 1'b1;
					del_data = {s_q.rx_sync, s_q.rx_frm[6:0]};
					s_d.rx_idx = 4'h0;
				end
			end
			if (s_q.tx_tick == SFU_TICK_LAST) begin
				s_d.tx_frm  = {1'b1, s_q.tx_frm[11:1]}; // [RQ16]
				s_d.tx_left = s_q.tx_left - 4'h1;
				fin = (s_q.tx_left == 4'h1);
			end
		end

		// Load a held byte as soon as the shifter runs dry; a byte written in
		// time follows the last stop bit with no idle gap.
		if ((s_q.tx_st == SFU_TX_IDLE || fin) && s_q.ctl[SFU_CTL_TX_ENABLE]
		    && !s_q.tx_empty_flag) begin // [RQ1] [RQ2] [RQ15]
			s_d.tx_frm  = sfu_frame(s_q.tx_holding_register, s_q.serial_format_register,
			                        s_q.ctl[SFU_CTL_MPROC_BIT]);
			s_d.tx_left = sfu_len(s_q.serial_format_register);
			s_d.tx_tick = 4'h0;
			s_d.tx_st   = SFU_TX_SHIFT;
			s_d.rx_idx  = sync_m ? 4'h0 : s_q.rx_idx;
			s_d.tx_empty_flag = 1'b1; // [RQ1]
			ev_set[SFU_EV_TX_EMPTY] = 1'b1;
		end else if (fin) begin
			// Nothing new was held: the line goes idle.
			s_d.tx_st = SFU_TX_IDLE;
			ev_set[SFU_EV_TX_END] = 1'b1;
		end

		// Asynchronous receiver with mid-bit sampling.
		if (sync_m || !s_q.ctl[SFU_CTL_RX_ENABLE]) begin
			s_d.rx_st = SFU_RX_IDLE;
		end else begin
			case (s_q.rx_st)
				SFU_RX_IDLE: begin
					// A low level may be a start bit.
					if (!s_q.rx_sync) begin
						s_d.rx_st   = SFU_RX_START;
						s_d.rx_tick = 4'h0;
					end
				end
				SFU_RX_START: begin
					if (tick) begin
						s_d.rx_tick = s_q.rx_tick + 4'h1;
						if (s_q.rx_tick == SFU_TICK_MID) begin
							// Still low at mid-bit: a real start; else a glitch.
							s_d.rx_st   = s_q.rx_sync ? SFU_RX_IDLE : SFU_RX_DATA;
							s_d.rx_tick = 4'h0;
							s_d.rx_idx  = 4'h1;
						end
					end
				end
				SFU_RX_DATA: begin
					if (tick) begin
						s_d.rx_tick = s_q.rx_tick + 4'h1;
						if (s_q.rx_tick == SFU_TICK_LAST) begin
							s_d.rx_frm[s_q.rx_idx] = s_q.rx_sync;
							s_d.rx_idx = s_q.rx_idx + 4'h1;
							if (s_q.rx_idx == pos) begin
								// Only the first stop bit is judged; the
								// receiver rearms at once, so a low second
								// stop bit is taken as the next start.
								s_d.rx_st = SFU_RX_IDLE; // [RQ12]
								del       = 1'b1;
								del_data  = s_q.rx_frm[8:1];
								if (sfu_ndata(s_q.serial_format_register) == 4'h7) begin
									del_data[7] = 1'b0;
								end
								del_ferr = !s_q.rx_sync; // [RQ12]
								if (s_q.serial_format_register[SFU_FMT_MULTIPROC_FORMAT]) begin
									s_d.mproc_rx = s_q.rx_frm[pos - 4'h1]; // [RQ13]
								end else if (s_q.serial_format_register[SFU_FMT_PARITY_ENABLE]) begin
									del_perr = s_q.rx_frm[pos - 4'h1]
									           != sfu_parity(del_data, s_q.serial_format_register); // [RQ10]
								end
							end
						end
					end
				end
				default: begin
					s_d.rx_st = SFU_RX_IDLE;
				end
			endcase
		end

		// Hand a received character over, unless the last one is unread.
		if (del) begin
			if (s_q.evt[SFU_EV_RX_FULL]) begin
				// The old byte is kept; the new one is lost.
				ev_set[SFU_EV_OVERRUN] = 1'b1;
			end else begin
				s_d.rxd = del_data;
				ev_set[SFU_EV_RX_FULL] = 1'b1;
				ev_set[SFU_EV_PARITY]  = del_perr;
				ev_set[SFU_EV_FRAMING] = del_ferr;
			end
		end

		// Bus slave: a request is answered with one cycle of waitrequest low.
		s_d.wait_n = 1'b1;
		if ((avs_read || avs_write) && s_q.wait_n) begin
			s_d.wait_n = 1'b0;
			case (avs_address)
				SFU_OFS_FMT:  s_d.rdata = {24'h00_0000, s_q.serial_format_register}; // [RQ4]
				SFU_OFS_TXH:  s_d.rdata = {24'h00_0000, s_q.tx_holding_register};    // [RQ3]
				SFU_OFS_CTL:  s_d.rdata = {29'h0000_0000, s_q.ctl};
				SFU_OFS_DIV:  s_d.rdata = {24'h00_0000, s_q.div};
				SFU_OFS_STAT: s_d.rdata = {28'h000_0000, s_q.mproc_rx, (s_q.rx_st != SFU_RX_IDLE),
				                           (s_q.tx_st == SFU_TX_SHIFT), s_q.tx_empty_flag};
				SFU_OFS_EVT:  s_d.rdata = {26'h000_0000, s_q.evt};
				SFU_OFS_MASK: s_d.rdata = {26'h000_0000, s_q.mask};
				SFU_OFS_RXD:  s_d.rdata = {24'h00_0000, s_q.rxd};
				default:      s_d.rdata = 32'h0000_0000;
			endcase
		end

		// Writes take effect on the edge that ends the answering cycle.
		if (avs_write && !s_q.wait_n) begin
			case (avs_address)
				SFU_OFS_FMT: begin
					s_d.serial_format_register = avs_writedata[7:0]; // [RQ4]
				end
				SFU_OFS_TXH: begin
					// Writing a byte marks it as new; a load in the same
					// cycle takes the old byte, so the new one stays held.
					s_d.tx_holding_register = avs_writedata[7:0]; // [RQ3]
					s_d.tx_empty_flag = 1'b0;
				end
				SFU_OFS_CTL:  s_d.ctl  = avs_writedata[2:0];
				SFU_OFS_DIV:  s_d.div  = avs_writedata[7:0];
				SFU_OFS_EVT:  ev_clr   = avs_writedata[5:0];
				SFU_OFS_MASK: s_d.mask = avs_writedata[5:0];
				default: begin
					// Read-only and unmapped offsets ignore writes.
				end
			endcase
		end

		// A disabled transmitter holds the empty flag at one.
		if (!s_d.ctl[SFU_CTL_TX_ENABLE]) begin
			s_d.tx_empty_flag = 1'b1;
		end

		// An event in the cycle of its clear survives: set wins.
		s_d.evt = (s_q.evt & ~ev_clr) | ev_set;
		s_d.irq = |(s_d.evt & s_d.mask);

		// Line outputs come from flops; idle level is high.
		s_d.txd = (s_d.tx_st == SFU_TX_SHIFT) ? s_d.tx_frm[0] : 1'b1; // [RQ16]
		s_d.sck = !(sync_m && s_d.tx_st == SFU_TX_SHIFT && s_d.tx_tick < SFU_TICK_MID);
	end

	// Register the whole state; reset puts every register at its documented value.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.serial_format_register <= SFU_FMT_RST; // [RQ4]
			s_q.tx_holding_register    <= SFU_TXH_RST; // [RQ3]
			s_q.ctl           <= SFU_CTL_RST;
			s_q.div           <= SFU_DIV_RST;
			s_q.evt           <= SFU_EVT_RST;
			s_q.tx_empty_flag <= 1'b1;
			s_q.tx_st         <= SFU_TX_IDLE;
			s_q.rx_st         <= SFU_RX_IDLE;
			s_q.txd           <= 1'b1;
			s_q.sck           <= 1'b1;
			s_q.wait_n        <= 1'b1;
			s_q.rx_meta       <= 1'b1;
			s_q.rx_sync       <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state flops.
	assign avs_readdata    = s_q.rdata;
	assign avs_waitrequest = s_q.wait_n;
	assign ser_txd         = s_q.txd;
	assign ser_sck         = s_q.sck;
	assign irq             = s_q.irq;

endmodule

/* File: core/sfu_pkg.sv */
// Constants and types shared by the serial format and transmit holding unit.
// Functional notes
// RQ1 - Empty shifter takes held byte, starts sending.
// RQ2 - Software refills holding register during shifting.
// RQ3 - Holding register always accessible, resets to ones.
// RQ4 - Format register always accessible, resets to zero.
// RQ5 - Format bit 7 picks asynchronous or synchronous.
// RQ6 - Bit 6 picks seven or eight bits.
// RQ7 - Seven-bit characters drop holding register bit 7.
// RQ8 - Bit 5 adds and checks parity, asynchronous only.
// RQ9 - Bit 4 picks even or odd parity.
// RQ10 - Parity makes total count of ones even/odd.
// RQ11 - Bit 3 gives one or two stop bits.
// RQ12 - Receiver checks only the first stop bit.
// RQ13 - Bit 2 selects multiprocessor format, overrides parity.
// RQ14 - Bits 1:0 pick clock divided 1/4/16/64.
// RQ15 - No transfer while the empty flag is set.
// RQ16 - Characters leave least significant bit first.
// RQ17 - Software sets format before enabling transmitter.
package sfu_pkg;

	// Register byte offsets on the bus.
	localparam logic [4:0] SFU_OFS_FMT  = 5'h00;
	localparam logic [4:0] SFU_OFS_TXH  = 5'h04;
	localparam logic [4:0] SFU_OFS_CTL  = 5'h08;
	localparam logic [4:0] SFU_OFS_DIV  = 5'h0C;
	localparam logic [4:0] SFU_OFS_STAT = 5'h10;
	localparam logic [4:0] SFU_OFS_EVT  = 5'h14;
	localparam logic [4:0] SFU_OFS_MASK = 5'h18;
	localparam logic [4:0] SFU_OFS_RXD  = 5'h1C;

	// Reset values.
	localparam logic [7:0] SFU_TXH_RST = 8'hFF;
	localparam logic [7:0] SFU_FMT_RST = 8'h00;
	localparam logic [7:0] SFU_DIV_RST = 8'hFF;
	localparam logic [2:0] SFU_CTL_RST = 3'h0;
	localparam logic [5:0] SFU_EVT_RST = 6'h00;

	// Format register fields.
	localparam int SFU_FMT_SYNC_MODE          = 7;
	localparam int SFU_FMT_CHAR_LENGTH_SELECT = 6;
	localparam int SFU_FMT_PARITY_ENABLE      = 5;
	localparam int SFU_FMT_ODD                = 4;
	localparam int SFU_FMT_TWO_STOP           = 3;
	localparam int SFU_FMT_MULTIPROC_FORMAT   = 2;
	localparam int SFU_FMT_PRESCALER_SELECT_HI = 1;
	localparam int SFU_FMT_PRESCALER_SELECT_LO = 0;

	// Control register fields.
	localparam int SFU_CTL_TX_ENABLE  = 0;
	localparam int SFU_CTL_RX_ENABLE  = 1;
	localparam int SFU_CTL_MPROC_BIT  = 2;

	// Live status register fields.
	localparam int SFU_ST_TX_EMPTY_FLAG = 0;
	localparam int SFU_ST_TX_BUSY       = 1;
	localparam int SFU_ST_RX_BUSY       = 2;
	localparam int SFU_ST_MPROC_BIT     = 3;

	// Sticky event bits, shared by the event and mask registers.
	localparam int SFU_EV_TX_EMPTY = 0;
	localparam int SFU_EV_TX_END   = 1;
	localparam int SFU_EV_RX_FULL  = 2;
	localparam int SFU_EV_PARITY   = 3;
	localparam int SFU_EV_FRAMING  = 4;
	localparam int SFU_EV_OVERRUN  = 5;

	// Prescaler tap codes.
	localparam logic [1:0] SFU_CKS_DIV1  = 2'h0;
	localparam logic [1:0] SFU_CKS_DIV4  = 2'h1;
	localparam logic [1:0] SFU_CKS_DIV16 = 2'h2;

	// Baud ticks per bit: sixteen, sampled in the middle.
	localparam logic [3:0] SFU_TICK_MID  = 4'h8;
	localparam logic [3:0] SFU_TICK_LAST = 4'hF;

	// Transmit and receive sequencer states.
	typedef enum logic {
		SFU_TX_IDLE  = 1'b0,
		SFU_TX_SHIFT = 1'b1
	} sfu_tx_st_t;

	typedef enum logic [1:0] {
		SFU_RX_IDLE  = 2'b00,
		SFU_RX_START = 2'b01,
		SFU_RX_DATA  = 2'b10
	} sfu_rx_st_t;

endpackage

/* File: core/sfu_baud.sv */
// Prescaler and bit-rate divider producing the sixteen-per-bit baud tick.
`timescale 1ns/1ps
module sfu_baud
	import sfu_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [1:0] prescaler_sel,
	input  wire logic [7:0] divisor,
	output logic            tick
);

	// All state of the divider.
	typedef struct packed {
		logic [5:0] pre;   // Free-running prescaler.
		logic [7:0] cnt;   // Divisor counter.
		logic       tick;  // Registered tick pulse.
	} sfu_baud_t;

	sfu_baud_t b_q;
	sfu_baud_t b_d;
	logic      tap;    // Chosen prescaler output pulse.

	// Pick the tap and count it down to one tick per divisor period.
	always_comb begin
		b_d = b_q;
		b_d.pre = b_q.pre + 6'h01;
		case (prescaler_sel) // [RQ14]
			SFU_CKS_DIV1:  tap = 1'b1;
			SFU_CKS_DIV4:  tap = (b_q.pre[1:0] == 2'h3);
			SFU_CKS_DIV16: tap = (b_q.pre[3:0] == 4'hF);
			default:       tap = (b_q.pre == 6'h3F);
		endcase
		b_d.tick = 1'b0;
		if (tap) begin
			// A divisor of N gives one tick every N+1 taps.
			if (b_q.cnt >= divisor) begin
				b_d.cnt  = 8'h00;
				b_d.tick = 1'b1;
			end else begin
				b_d.cnt = b_q.cnt + 8'h01;
			end
		end
	end

	// Register the whole state.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			b_q <= '0;
		end else begin
			b_q <= b_d;
		end
	end

	assign tick = b_q.tick;

endmodule

/* File: tb/sfu_core_sva.sv */
// Assertions on the bus handshake, register readback, transmit line and interrupt of the serial unit.
`timescale 1ns/1ps
module sfu_core_sva
	import sfu_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        ser_rxd,
	input wire logic        ser_txd,
	input wire logic        ser_sck,
	input wire logic        irq
);
	logic [7:0] fmt_q;  // Shadow of the format register.
	logic [7:0] txh_q;  // Shadow of the holding register.
	logic [5:0] mask_q; // Shadow of the interrupt mask.
	logic       ten_q;  // Shadow of the transmit enable.
	wire        wr_ok    = avs_write && !avs_waitrequest;
	wire        rd_ok    = avs_read && !avs_waitrequest;
	wire        is_async = !fmt_q[7];
	wire        mask_off = mask_q == 6'h00;

	// Shadows follow each accepted write, so readback and quiet periods can be predicted.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fmt_q  <= 8'h00;
			txh_q  <= 8'hFF;
			mask_q <= 6'h00;
			ten_q  <= 1'b0;
		end else if (wr_ok) begin
			if (avs_address == SFU_OFS_FMT) fmt_q <= avs_writedata[7:0];
			if (avs_address == SFU_OFS_TXH) txh_q <= avs_writedata[7:0];
			if (avs_address == SFU_OFS_MASK) mask_q <= avs_writedata[5:0];
			if (avs_address == SFU_OFS_CTL) ten_q <= avs_writedata[0];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Half of the shortest bit time; a bit lasts at least sixteen clocks at the fastest tap.
	sequence s_low8;
		!ser_txd [*8];
	endsequence

	a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer held longer than one cycle");
	a_wait_no_req: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
		else $error("answer given without a request");
	a_fmt_readback: assert property (rd_ok && avs_address == SFU_OFS_FMT |-> avs_readdata == 32'(fmt_q))
		else $error("format register read differs from last write");
	a_txh_readback: assert property (rd_ok && avs_address == SFU_OFS_TXH |-> avs_readdata == 32'(txh_q))
		else $error("holding register read differs from last write");
	a_start_width: assert property ($fell(ser_txd) |-> s_low8 ##1 s_low8)
		else $error("low bit shorter than sixteen clocks");
	a_idle_disabled: assert property (!ten_q && !$past(ten_q) && ser_txd |=> ser_txd)
		else $error("line left idle while transmitter is disabled");
	a_async_no_sck: assert property (is_async && $past(is_async) |-> ser_sck)
		else $error("serial clock toggles in asynchronous mode");
	a_irq_masked: assert property (mask_off && $past(mask_off) |-> !irq)
		else $error("interrupt raised with every event masked");
endmodule

/* File: tb/sfu_peer.sv */
// Behavioural remote serial peer: decodes frames from the transmit line and loops the line back.
`timescale 1ns/1ps
module sfu_peer (
	input wire logic        clk,
	input wire logic        ser_txd,
	input wire logic        ser_sck,
	input wire logic        sync,
	input wire logic [15:0] bit_clks,
	input wire logic [3:0]  nb,
	input wire logic        npar,
	input wire logic [1:0]  ns,
	output logic            ser_rxd,
	output logic [7:0]      rx_byte,
	output logic            rx_par,
	output logic [1:0]      rx_stop,
	output int              rx_cnt
);
	assign ser_rxd = ser_txd; // Loopback, so the unit's receiver hears every frame it sends.
	// Bits are sampled mid-bit; results are published together so the bench never sees half a frame.
	initial begin
		logic [7:0] b;
		logic       p;
		logic [1:0] s;
		rx_cnt  = 0;
		rx_byte = 8'h00;
		forever begin
			b = 8'h00;
			p = 1'b0;
			s = 2'b00;
			@(negedge ser_txd or negedge ser_sck);
			if (sync) begin
				// Synchronous bits are taken on the rising serial clock.
				for (int i = 0; i < 8; i++) begin
					@(posedge ser_sck);
					b[i] = ser_txd;
				end
			end else begin
				repeat (bit_clks / 2) @(posedge clk);
				for (int i = 0; i < nb; i++) begin
					repeat (bit_clks) @(posedge clk);
					b[i] = ser_txd;
				end
				if (npar) begin
					repeat (bit_clks) @(posedge clk);
					p = ser_txd;
				end
				repeat (bit_clks) @(posedge clk);
				s[0] = ser_txd;
				// The second stop is looked at only when two are expected.
				if (ns > 1) begin
					repeat (bit_clks) @(posedge clk);
					s[1] = ser_txd;
				end
			end
			rx_byte = b;
			rx_par  = p;
			rx_stop = s;
			rx_cnt++;
		end
	end
endmodule

/* File: tb/sfu_core_tb.sv */
// Self-checking bench for the serial format unit: registers, frame formats, loopback receive and interrupt.
`timescale 1ns/1ps
module sfu_core_tb
	import sfu_pkg::*;
;
	logic        clk;
	logic        sys_rst;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        ser_rxd;
	logic        ser_txd;
	logic        ser_sck;
	logic        irq;
	logic        p_sync;
	logic [15:0] p_bclk;
	logic [3:0]  p_nb;
	logic        p_par;
	logic [1:0]  p_ns;
	logic [7:0]  rx_byte;
	logic        rx_par;
	logic [1:0]  rx_stop;
	int          rx_cnt;
	int          fail_count = 0;
	int          n_compared = 0;
	int          cyc = 0;
	logic [31:0] seed = 32'h0000_5039;
	logic [31:0] rd;
	logic [7:0]  fmts [5] = '{8'h00, 8'h61, 8'h3A, 8'h27, 8'h10}; // Every tap, length, parity and stop mix.

	sfu_core i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ser_rxd(ser_rxd), .ser_txd(ser_txd), .ser_sck(ser_sck), .irq(irq));
	sfu_peer i_peer (.clk(clk), .ser_txd(ser_txd), .ser_sck(ser_sck), .sync(p_sync), .bit_clks(p_bclk),
		.nb(p_nb), .npar(p_par), .ns(p_ns), .ser_rxd(ser_rxd), .rx_byte(rx_byte), .rx_par(rx_par),
		.rx_stop(rx_stop), .rx_cnt(rx_cnt));

	// Free-running 40 MHz clock and a cycle count for gap measurement.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One bus cycle; the request is held until waitrequest is seen low at a rising edge.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic wait_rx(input int n);
		while (rx_cnt < n) @(negedge clk);
	endtask

	function automatic logic [7:0] rnd8();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction

	// Seven-bit characters lose the top bit; synchronous mode always keeps eight.
	function automatic logic [7:0] exp_byte(input logic [7:0] f, input logic [7:0] d);
		return (f[6] && !f[7]) ? {1'b0, d[6:0]} : d;
	endfunction

	// The multiprocessor bit replaces parity; the bench always sends it as one.
	function automatic logic exp_par(input logic [7:0] f, input logic [7:0] d);
		return f[2] ? 1'b1 : (^exp_byte(f, d)) ^ f[4];
	endfunction

	// Format is set with both directions off and events cleared, then both are enabled, multiprocessor bit at one.
	task automatic cfg(input logic [7:0] f);
		bus(1'b1, SFU_OFS_CTL, 32'h0000_0000);
		bus(1'b1, SFU_OFS_EVT, 32'h0000_003F);
		bus(1'b1, SFU_OFS_FMT, 32'(f));
		bus(1'b1, SFU_OFS_CTL, 32'h0000_0007);
		p_sync = f[7];
		p_nb   = f[6] ? 4'h7 : 4'h8;
		p_par  = f[5] | f[2];
		p_ns   = f[3] ? 2'h2 : 2'h1;
		p_bclk = 16'h0010 << (2 * f[1:0]);
	endtask

	task automatic send1(input logic [7:0] f);
		logic [7:0] d;
		int         n0;
		d  = rnd8();
		n0 = rx_cnt;
		cfg(f);
		bus(1'b1, SFU_OFS_TXH, 32'(d));
		wait_rx(n0 + 1);
		chk(rx_byte, exp_byte(f, d));
		chk(rx_par, p_par ? exp_par(f, d) : 1'b0);
		chk(rx_stop, p_ns == 2'h2 ? 2'h3 : 2'h1);
		rd = 32'h0000_0000; // The looped-back frame must land with no error.
		while (rd[SFU_EV_RX_FULL] !== 1'b1) bus(1'b0, SFU_OFS_EVT, 32'h0000_0000);
		chk(rd[5:2], 4'h1);
		bus(1'b0, SFU_OFS_RXD, 32'h0000_0000);
		chk(rd, 32'(exp_byte(f, d)));
		$display("frame format %h done", f);
	endtask

	// Second byte is written while the first shifts; frames must follow with no idle gap.
	task automatic b2b(input logic [7:0] f, input int bits);
		logic [7:0] a;
		logic [7:0] b;
		int         n0;
		int         t0;
		a  = rnd8();
		b  = rnd8();
		n0 = rx_cnt;
		cfg(f);
		bus(1'b1, SFU_OFS_MASK, 32'h0000_0001);
		bus(1'b1, SFU_OFS_TXH, 32'(a));
		rd = 32'h0000_0000;
		while (rd[SFU_ST_TX_EMPTY_FLAG] !== 1'b1) bus(1'b0, SFU_OFS_STAT, 32'h0000_0000);
		@(negedge clk);
		chk(irq, 1'b1);
		bus(1'b1, SFU_OFS_TXH, 32'(b));
		wait_rx(n0 + 1);
		t0 = cyc;
		chk(rx_byte, a);
		wait_rx(n0 + 2);
		chk(cyc - t0, bits * 16);
		chk(rx_byte, b);
		bus(1'b1, SFU_OFS_EVT, 32'h0000_003F);
		repeat (2) @(negedge clk);
		chk(irq, 1'b0);
		bus(1'b1, SFU_OFS_MASK, 32'h0000_0000);
		$display("back to back %h done", f);
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		logic [7:0] d;
		logic [7:0] e;
		int         n;
		sys_rst       = 1'b1;
		avs_address   = 5'h00;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = 32'h0000_0000;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		bus(1'b0, SFU_OFS_FMT, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		bus(1'b0, SFU_OFS_TXH, 32'h0000_0000);
		chk(rd, 32'h0000_00FF);
		bus(1'b0, 5'h02, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		// Random patterns, with the transmitter off so nothing is sent.
		repeat (4) begin
			d = rnd8();
			e = rnd8();
			bus(1'b1, SFU_OFS_FMT, 32'(d));
			bus(1'b1, SFU_OFS_TXH, 32'(e));
			bus(1'b0, SFU_OFS_FMT, 32'h0000_0000);
			chk(rd, 32'(d));
			bus(1'b0, SFU_OFS_TXH, 32'h0000_0000);
			chk(rd, 32'(e));
		end
		$display("register access done");
		bus(1'b1, SFU_OFS_DIV, 32'h0000_0000);
		b2b(8'h00, 10);
		foreach (fmts[i]) send1(fmts[i]);
		// A held byte must not leave while the transmitter is off.
		cfg(8'h00);
		bus(1'b1, SFU_OFS_CTL, 32'h0000_0000);
		n = rx_cnt;
		bus(1'b1, SFU_OFS_TXH, 32'h0000_00A5);
		repeat (300) @(negedge clk);
		chk(rx_cnt, n);
		bus(1'b0, SFU_OFS_STAT, 32'h0000_0000);
		chk(rd[SFU_ST_TX_EMPTY_FLAG], 1'b1);
		$display("disabled transmitter done");
		b2b(8'hFC, 8);
		// Reset in mid-frame returns both registers to their initial values.
		cfg(8'h3A);
		bus(1'b1, SFU_OFS_TXH, 32'h0000_0055);
		repeat (40) @(posedge clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		bus(1'b0, SFU_OFS_FMT, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		bus(1'b0, SFU_OFS_TXH, 32'h0000_0000);
		chk(rd, 32'h0000_00FF);
		$display("reset in frame done");
		summarize();
	end

	// Watchdog sized well above the slowest frame sequence.
	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		summarize();
	end
endmodule

bind sfu_core sfu_core_sva i_sva (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .ser_rxd(ser_rxd), .ser_txd(ser_txd), .ser_sck(ser_sck), .irq(irq));
